// ---- hw/tcsbt_frame_gen.sv ----
// Backplane frame pulse divider and shaper for the master role
`timescale 1ns/100ps
module tcsbt_frame_gen (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_bit_clock,
    input wire logic i_double_rate,
    input wire logic i_format,
    output logic o_frame_pulse
);
    typedef struct packed {
        logic clk_prev;
        logic [9:0] count;
        logic pulse;
    } tcsbt_frame_t;

    tcsbt_frame_t st_reg;
    tcsbt_frame_t st_next;
    logic [9:0] last;

    // Count bit clock rising edges, one frame per wrap
    always_comb
    begin
        st_next = st_reg;
        last = i_double_rate ? tcsbt_pkg::FRAME_LAST_2X : tcsbt_pkg::FRAME_LAST_1X;
        st_next.clk_prev = i_bit_clock;
        if (!i_enable)
        begin
            st_next.count = tcsbt_pkg::FRAME_COUNT_RESET;
            st_next.pulse = (i_format == tcsbt_pkg::FORMAT_LOW_END);
        end
        else
        begin
            if (i_bit_clock && !st_reg.clk_prev)
                st_next.count = (st_reg.count == last) ? 10'h000 : st_reg.count + 10'h001;
            // Low-going pulse in the last bit, or high pulse in the first
            if (i_format == tcsbt_pkg::FORMAT_LOW_END)
                st_next.pulse = (st_next.count != last);
            else
                st_next.pulse = (st_next.count == 10'h000);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= '0;
            st_reg.pulse <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    assign o_frame_pulse = st_reg.pulse;
endmodule

// ---- hw/tcsbt_sync3.sv ----
// Three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/100ps
module tcsbt_sync3 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } tcsbt_sync_t;

    tcsbt_sync_t st_reg;
    tcsbt_sync_t st_next;
    logic [W-1:0] agree;

    // A bit changes only once stages two and three agree
    always_comb
    begin
        st_next = st_reg;
        agree = ~(st_reg.s2 ^ st_reg.s3);
        st_next.s1 = i_async;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q = (st_reg.s3 & agree) | (st_reg.q & ~agree);
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign o_sync = st_reg.q;
endmodule

// ---- hw/tcsbt_top.sv ----
// Per-port output clock muxes, reference selection and backplane timing
`timescale 1ns/100ps
// What this block does
// - Four output clock sources per port
// - Reset selects system clock divided by two
// - Select field at base plus sixteen per port
// - Loss swaps input clock for recovered clock
// - Loss puts port PLL into holdover
// - PLL reference mode chosen by software
// - Recovered clock feeds own port mux
// - Network mode references divided 8 kHz clock
// - One shared bidirectional backplane clock, pulse
// - Slave routes incoming backplane clock inward
// - Slave passes frame pulse unchanged
// - Master drives clock and pulse everywhere
// - Master frame pulse divides backplane clock
// - Frame pulse shaped to chosen format
// - External reference takes pin clock
// - Internal reference takes primary reference
// - Sixteen sources for each reference
// - Reference loss follows selected port loss
// - Loss forces primary to recovered clock
// - Secondary selection never overridden
// - Backplane clock at one or two times
module tcsbt_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [15:0] i_cpu_addr,
    input wire logic [15:0] i_cpu_wdata,
    input wire logic i_cpu_write,
    input wire logic i_cpu_read,
    output logic [15:0] o_cpu_rdata,
    // Per-port clocks and loss indications
    input wire logic [7:0] i_port_input_clock,
    input wire logic [7:0] i_port_recovered_clock,
    input wire logic [7:0] i_signal_loss,
    input wire logic i_network_ref_8k,
    input wire logic i_ext_pll_clock,
    // Device-wide configuration levels
    input wire logic i_backplane_mode,
    input wire logic i_backplane_master,
    input wire logic i_backplane_double_rate,
    input wire logic i_frame_format,
    input wire logic i_common_external,
    input wire logic [3:0] i_primary_select,
    input wire logic [3:0] i_secondary_select,
    // Backplane pins, split into in, out and enable
    input wire logic i_backplane_bit_clock,
    output logic o_backplane_bit_clock,
    output logic o_backplane_bit_clock_oe,
    input wire logic i_backplane_frame_pulse,
    output logic o_backplane_frame_pulse,
    output logic o_backplane_frame_pulse_oe,
    // Towards the TDM interface and the PLLs
    output logic [7:0] o_port_output_clock,
    output logic [7:0] o_pll_holdover,
    output logic [7:0] o_pll_reference,
    output logic [15:0] o_pll_ref_mode,
    output logic o_tdm_bit_clock,
    output logic o_tdm_frame_pulse,
    output logic o_common_clock,
    output logic o_primary_reference,
    output logic o_secondary_reference,
    output logic o_primary_reference_loss,
    output logic o_secondary_reference_loss
);
    typedef struct packed {
        logic [7:0][15:0] cfg;
        logic [7:0] out_clk;
        logic [7:0] subst;
        logic [7:0] holdover;
        logic [7:0] pll_ref;
        logic [15:0] rdata;
        logic div2;
        logic primary_reference;
        logic secondary_reference;
        logic primary_reference_loss;
        logic secondary_reference_loss;
        logic common_clk;
        logic common_prev;
        logic bp_gen;
        logic bp_gen_d;
        logic bp_clk_out;
        logic bp_clk_oe;
        logic bp_fp_out;
        logic bp_fp_oe;
        logic tdm_clk;
        logic tdm_fp;
    } tcsbt_state_t;

    tcsbt_state_t st_reg;
    tcsbt_state_t st_next;
    logic [10:0] sync_out;
    logic [7:0] in_clk;
    logic ext_clk;
    logic bp_clk_in;
    logic bp_fp_in;
    logic fp_gen;
    logic master_on;

    // True for an aligned per-port register address
    function automatic logic is_cfg_addr(input logic [15:0] addr);
        logic [15:0] off;
        off = addr - tcsbt_pkg::CFG_BASE;
        return (addr >= tcsbt_pkg::CFG_BASE) && (off < tcsbt_pkg::CFG_SPAN) && (off[3:0] == 4'h0);
    endfunction

    // Port number of a per-port register address
    function automatic logic [2:0] cfg_index(input logic [15:0] addr);
        logic [15:0] off;
        off = addr - tcsbt_pkg::CFG_BASE;
        return off[6:4];
    endfunction

    // One bit of an eight-port vector
    function automatic logic port_bit(input logic [7:0] vec, input logic [2:0] idx);
        return vec[idx];
    endfunction

    // Pins pass four flops (three stages and the filter); recovered clocks are on our clock
    tcsbt_sync3 #(
        .W(11)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_ext_pll_clock, i_backplane_bit_clock, i_backplane_frame_pulse, i_port_input_clock}),
        .o_sync(sync_out)
    );

    assign in_clk = sync_out[7:0];
    assign bp_fp_in = sync_out[8];
    assign bp_clk_in = sync_out[9];
    assign ext_clk = sync_out[10];
    assign master_on = i_backplane_mode && i_backplane_master;

    // Frame pulse divided from the generated backplane clock
    tcsbt_frame_gen u_frame (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(master_on),
        .i_bit_clock(st_reg.bp_gen),
        .i_double_rate(i_backplane_double_rate),
        .i_format(i_frame_format),
        .o_frame_pulse(fp_gen)
    );

    // Next state of every register in the block
    always_comb
    begin
        logic [1:0] sel;
        logic [1:0] mode;
        logic [2:0] pidx;
        logic [2:0] sidx;
        logic pri_pll;
        logic common_now;
        st_next = st_reg;
        sel = 2'h0;
        mode = 2'h0;
        pidx = i_primary_select[2:0];
        sidx = i_secondary_select[2:0];
        pri_pll = 1'b0;
        common_now = 1'b0;

        // Free-running system clock divided by two
        st_next.div2 = ~st_reg.div2;

        // Register writes; only the defined fields are kept
        if (i_cpu_write && is_cfg_addr(i_cpu_addr))
            st_next.cfg[cfg_index(i_cpu_addr)] = i_cpu_wdata & tcsbt_pkg::CFG_WRITE_MASK;

        // Reads show fields plus live loss and substitution state
        if (i_cpu_read)
        begin
            if (is_cfg_addr(i_cpu_addr))
            begin
                st_next.rdata = st_reg.cfg[cfg_index(i_cpu_addr)];
                st_next.rdata[tcsbt_pkg::LOSS_BIT] = port_bit(i_signal_loss, cfg_index(i_cpu_addr));
                st_next.rdata[tcsbt_pkg::SUBST_BIT] = port_bit(st_reg.subst, cfg_index(i_cpu_addr));
            end
            else
                st_next.rdata = 16'h0000;
        end

        // Primary reference: loss on the chosen port forces its PLL clock
        pri_pll = i_primary_select[3] || port_bit(i_signal_loss, pidx);
        st_next.primary_reference = pri_pll ? port_bit(i_port_recovered_clock, pidx) : port_bit(in_clk, pidx);
        st_next.primary_reference_loss = port_bit(i_signal_loss, pidx);

        // Secondary reference keeps the software choice under loss
        st_next.secondary_reference = i_secondary_select[3] ? port_bit(i_port_recovered_clock, sidx)
                                                : port_bit(in_clk, sidx);
        st_next.secondary_reference_loss = port_bit(i_signal_loss, sidx);

        // Common line-rate clock from the pin or the primary reference
        common_now = i_common_external ? ext_clk : st_next.primary_reference;
        st_next.common_clk = common_now;

        // Per-port output clock muxes and PLL reference steering
        for (int p = 0; p < tcsbt_pkg::NUM_PORTS; p++)
        begin
            sel = st_reg.cfg[p][tcsbt_pkg::SEL_LSB +: 2];
            mode = st_reg.cfg[p][tcsbt_pkg::MODE_LSB +: 2];
            // Substitution lasts only while loss is present
            st_next.subst[p] = (sel == tcsbt_pkg::SEL_INPUT) && i_signal_loss[p];
            case (sel)
                tcsbt_pkg::SEL_INPUT:
                    st_next.out_clk[p] = i_signal_loss[p] ? i_port_recovered_clock[p] : in_clk[p];
                tcsbt_pkg::SEL_RECOVERED:
                    st_next.out_clk[p] = i_port_recovered_clock[p];
                tcsbt_pkg::SEL_COMMON:
                    st_next.out_clk[p] = common_now;
                default:
                    st_next.out_clk[p] = st_reg.div2;
            endcase
            // Holdover keeps the recovered clock valid through a loss
            st_next.holdover[p] = i_signal_loss[p];
            // Stamp and adaptive references come from their own logic
            case (mode)
                tcsbt_pkg::MODE_LINE:
                    st_next.pll_ref[p] = in_clk[p];
                tcsbt_pkg::MODE_NETWORK:
                    st_next.pll_ref[p] = i_network_ref_8k;
                default:
                    st_next.pll_ref[p] = 1'b0;
            endcase
        end

        // Backplane clock generation from the common clock
        st_next.common_prev = common_now;
        if (master_on)
        begin
            if (i_backplane_double_rate)
                st_next.bp_gen = common_now;
            else if (common_now && !st_reg.common_prev)
                st_next.bp_gen = ~st_reg.bp_gen;
        end
        else
            st_next.bp_gen = 1'b0;
        // Delay matches the one-cycle lag of the frame generator
        st_next.bp_gen_d = st_reg.bp_gen;

        // Backplane roles: master drives, slave listens
        if (master_on)
        begin
            st_next.bp_clk_out = st_reg.bp_gen_d;
            st_next.bp_clk_oe = 1'b1;
            st_next.bp_fp_out = fp_gen;
            st_next.bp_fp_oe = 1'b1;
            st_next.tdm_clk = st_reg.bp_gen_d;
            st_next.tdm_fp = fp_gen;
        end
        else if (i_backplane_mode)
        begin
            st_next.bp_clk_out = 1'b0;
            st_next.bp_clk_oe = 1'b0;
            st_next.bp_fp_out = 1'b0;
            st_next.bp_fp_oe = 1'b0;
            st_next.tdm_clk = bp_clk_in;
            st_next.tdm_fp = bp_fp_in;
        end
        else
        begin
            st_next.bp_clk_out = 1'b0;
            st_next.bp_clk_oe = 1'b0;
            st_next.bp_fp_out = 1'b0;
            st_next.bp_fp_oe = 1'b0;
            st_next.tdm_clk = 1'b0;
            st_next.tdm_fp = 1'b0;
        end
    end

    // State register; every port starts on the divided system clock
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= '0;
            st_reg.cfg <= {8{tcsbt_pkg::CFG_RESET}};
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from the state register
    assign o_cpu_rdata = st_reg.rdata;
    assign o_port_output_clock = st_reg.out_clk;
    assign o_pll_holdover = st_reg.holdover;
    assign o_pll_reference = st_reg.pll_ref;
    assign o_tdm_bit_clock = st_reg.tdm_clk;
    assign o_tdm_frame_pulse = st_reg.tdm_fp;
    assign o_common_clock = st_reg.common_clk;
    assign o_primary_reference = st_reg.primary_reference;
    assign o_secondary_reference = st_reg.secondary_reference;
    assign o_primary_reference_loss = st_reg.primary_reference_loss;
    assign o_secondary_reference_loss = st_reg.secondary_reference_loss;
    assign o_backplane_bit_clock = st_reg.bp_clk_out;
    assign o_backplane_bit_clock_oe = st_reg.bp_clk_oe;
    assign o_backplane_frame_pulse = st_reg.bp_fp_out;
    assign o_backplane_frame_pulse_oe = st_reg.bp_fp_oe;

    // PLL mode fields of all ports, two bits each
    always_comb
    begin
        for (int p = 0; p < tcsbt_pkg::NUM_PORTS; p++)
            o_pll_ref_mode[2*p +: 2] = st_reg.cfg[p][tcsbt_pkg::MODE_LSB +: 2];
    end
endmodule

// ---- include/tcsbt_pkg.sv ----
// Constants shared by the clock selection and backplane timing design
package tcsbt_pkg;
    // Port count and per-port configuration register map
    localparam int NUM_PORTS = 8;
    localparam logic [15:0] CFG_BASE = 16'h5200;
    localparam logic [15:0] CFG_STRIDE = 16'h0010;
    localparam logic [15:0] CFG_SPAN = 16'h0080;
    localparam logic [15:0] CFG_RESET = 16'h0003;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h000f;
    // Field positions inside the configuration register
    localparam int SEL_LSB = 0;
    localparam int MODE_LSB = 2;
    localparam int LOSS_BIT = 4;
    localparam int SUBST_BIT = 5;
    // Output clock source codes
    localparam logic [1:0] SEL_INPUT = 2'h0;
    localparam logic [1:0] SEL_RECOVERED = 2'h1;
    localparam logic [1:0] SEL_COMMON = 2'h2;
    localparam logic [1:0] SEL_SYS_DIV2 = 2'h3;
    // Reference modes of the per-port internal PLL
    localparam logic [1:0] MODE_LINE = 2'h0;
    localparam logic [1:0] MODE_NETWORK = 2'h1;
    localparam logic [1:0] MODE_STAMP = 2'h2;
    localparam logic [1:0] MODE_ADAPTIVE = 2'h3;
    // Last count of a frame in backplane bit clocks at one and two times the data rate
    localparam logic [9:0] FRAME_LAST_1X = 10'h0ff;
    localparam logic [9:0] FRAME_LAST_2X = 10'h1ff;
    // Reset values of the frame pulse generator
    localparam logic [9:0] FRAME_COUNT_RESET = 10'h000;
    // Frame pulse formats
    localparam logic FORMAT_LOW_END = 1'b0;
    localparam logic FORMAT_HIGH_START = 1'b1;
endpackage

// ---- tb/tcsbt_checker_assertions.sv ----
// Port-level checker for the clock selection and backplane timing block
`timescale 1ns/100ps
module tcsbt_checker (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_port_recovered_clock,
    input wire logic [7:0] i_signal_loss,
    input wire logic i_common_external,
    input wire logic i_backplane_mode,
    input wire logic i_backplane_master,
    input wire logic [3:0] i_primary_select,
    input wire logic [3:0] i_secondary_select,
    input wire logic o_backplane_bit_clock,
    input wire logic o_backplane_bit_clock_oe,
    input wire logic o_backplane_frame_pulse,
    input wire logic o_backplane_frame_pulse_oe,
    input wire logic [7:0] o_pll_holdover,
    input wire logic o_tdm_bit_clock,
    input wire logic o_tdm_frame_pulse,
    input wire logic o_common_clock,
    input wire logic o_primary_reference,
    input wire logic o_secondary_reference,
    input wire logic o_primary_reference_loss,
    input wire logic o_secondary_reference_loss
);
    // Selected-port views, all in the same clock domain
    wire pri_loss = i_signal_loss[i_primary_select[2:0]];
    wire sec_loss = i_signal_loss[i_secondary_select[2:0]];
    wire pri_rec = i_port_recovered_clock[i_primary_select[2:0]];
    wire sec_rec = i_port_recovered_clock[i_secondary_select[2:0]];
    wire pri_rec_sel = i_primary_select[3];
    wire sec_rec_sel = i_secondary_select[3];
    logic [3:0] mst_cnt_reg;
    logic [3:0] mst_cnt_next;
    // Cycles in master role, saturating; pipelines need time to fill
    always_comb
        mst_cnt_next = (i_backplane_mode && i_backplane_master) ? mst_cnt_reg + {3'h0, mst_cnt_reg != 4'hf} : 4'h0;
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            mst_cnt_reg <= 4'h0;
        else
            mst_cnt_reg <= mst_cnt_next;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    a_holdover_copy: assert property ($past(i_reset_n) |-> o_pll_holdover == $past(i_signal_loss))
        else $error("holdover does not follow loss");
    a_ref_loss: assert property ($past(i_reset_n) |-> o_primary_reference_loss == $past(pri_loss)
        && o_secondary_reference_loss == $past(sec_loss)) else $error("reference loss wrong port");
    a_pri_override: assert property ($past(i_reset_n) && ($past(pri_loss) || $past(pri_rec_sel))
        |-> o_primary_reference == $past(pri_rec)) else $error("primary not recovered clock");
    a_sec_keep: assert property ($past(i_reset_n) && $past(sec_rec_sel)
        |-> o_secondary_reference == $past(sec_rec)) else $error("secondary selection altered");
    a_common_int: assert property ($past(i_reset_n) && !i_common_external && !$past(i_common_external)
        |-> o_common_clock == o_primary_reference) else $error("common clock not primary");
    a_idle_off: assert property ($past(i_reset_n) && !$past(i_backplane_mode) |-> !(o_backplane_bit_clock_oe
        || o_backplane_frame_pulse_oe || o_tdm_bit_clock || o_tdm_frame_pulse)) else $error("backplane active");
    a_master_drive: assert property (mst_cnt_reg == 4'hf
        |-> o_backplane_bit_clock_oe && o_backplane_frame_pulse_oe) else $error("master not driving pins");
    a_master_mirror: assert property (mst_cnt_reg == 4'hf |-> o_backplane_bit_clock == o_tdm_bit_clock
        && o_backplane_frame_pulse == o_tdm_frame_pulse) else $error("pins differ from TDM side");
    a_frame_edge: assert property (mst_cnt_reg == 4'hf && $changed(o_tdm_frame_pulse)
        |-> $rose(o_tdm_bit_clock)) else $error("frame pulse off clock edge");
endmodule
bind tcsbt_top tcsbt_checker u_checker (.*);

// ---- tb/tcsbt_far_end.sv ----
// Far-side model: external PLL clock source and backplane peer
`timescale 1ns/100ps
module tcsbt_far_end (
    input wire logic i_clk,
    input wire logic i_ext_run,
    input wire logic i_ext_level,
    input wire logic i_peer_drive,
    input wire logic i_peer_clock,
    input wire logic i_peer_frame,
    input wire logic i_dev_clock,
    input wire logic i_dev_clock_oe,
    input wire logic i_dev_frame,
    input wire logic i_dev_frame_oe,
    output logic o_ext_pll_clock,
    output logic o_pin_clock,
    output logic o_pin_frame
);
    logic ph = 1'h0;
    logic ext_clk = 1'h0;
    logic clk_last = 1'h0;
    logic frm_last = 1'h0;
    // Line-rate clock toggles every two cycles while running
    always @(posedge i_clk)
    begin
        ph <= ~ph;
        if (ph)
            ext_clk <= ~ext_clk;
        clk_last <= o_pin_clock;
        frm_last <= o_pin_frame;
    end
    assign o_ext_pll_clock = i_ext_run ? ext_clk : i_ext_level;
    // Shared wires; nobody driving shows a changing level, not a stale one
    assign o_pin_clock = i_dev_clock_oe ? i_dev_clock : (i_peer_drive ? i_peer_clock : ~clk_last);
    assign o_pin_frame = i_dev_frame_oe ? i_dev_frame : (i_peer_drive ? i_peer_frame : ~frm_last);
endmodule

// ---- tb/tcsbt_top_tb.sv ----
// Self-checking testbench for the clock selection and backplane timing block
`timescale 1ns/100ps
module tcsbt_top_tb;
    typedef struct packed {logic [2:0] kind; logic [15:0] val;} tcsbt_note_t;
    logic i_clk = 1'h0, i_reset_n = 1'h0, i_cpu_write = 1'h0, i_cpu_read = 1'h0, i_network_ref_8k = 1'h0;
    logic i_backplane_mode = 1'h0, i_backplane_master = 1'h0, i_backplane_double_rate = 1'h0;
    logic i_frame_format = 1'h0, i_common_external = 1'h0;
    logic [15:0] i_cpu_addr = 16'h0000, i_cpu_wdata = 16'h0000, o_cpu_rdata, o_pll_ref_mode;
    logic [7:0] i_port_input_clock = 8'h00, i_port_recovered_clock = 8'h00, i_signal_loss = 8'h00;
    logic [3:0] i_primary_select = 4'h0, i_secondary_select = 4'h0;
    logic [7:0] o_port_output_clock, o_pll_holdover, o_pll_reference;
    logic i_ext_pll_clock, i_backplane_bit_clock, i_backplane_frame_pulse, o_common_clock;
    logic o_backplane_bit_clock, o_backplane_bit_clock_oe, o_backplane_frame_pulse, o_backplane_frame_pulse_oe;
    logic o_tdm_bit_clock, o_tdm_frame_pulse, o_primary_reference, o_secondary_reference;
    logic o_primary_reference_loss, o_secondary_reference_loss;
    logic ext_run = 1'h0, ext_level = 1'h0, peer_drive = 1'h0, peer_clock = 1'h0, peer_frame = 1'h0;
    logic req = 1'h0, req_q, req_q2;
    logic [9:0] meas = 10'h000;
    int n_fail = 0, n_tests = 0;
    tcsbt_note_t notes[$];

    tcsbt_top uut (.*);
    tcsbt_far_end u_far (.i_clk(i_clk), .i_ext_run(ext_run), .i_ext_level(ext_level), .i_peer_drive(peer_drive),
        .i_peer_clock(peer_clock), .i_peer_frame(peer_frame), .i_dev_clock(o_backplane_bit_clock),
        .i_dev_clock_oe(o_backplane_bit_clock_oe), .i_dev_frame(o_backplane_frame_pulse),
        .i_dev_frame_oe(o_backplane_frame_pulse_oe), .o_ext_pll_clock(i_ext_pll_clock),
        .o_pin_clock(i_backplane_bit_clock), .o_pin_frame(i_backplane_frame_pulse));

    // Clock at 100 ns period
    always #50 i_clk = ~i_clk;

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic judge(input tcsbt_note_t n);
        logic [15:0] act;
        case (n.kind)
            3'h0: act = o_cpu_rdata;
            3'h1: act = {o_port_output_clock, o_pll_holdover};
            3'h2: act = {o_pll_reference, 3'h0, o_common_clock, o_primary_reference, o_secondary_reference,
                o_primary_reference_loss, o_secondary_reference_loss};
            3'h3: act = o_pll_ref_mode;
            3'h4: act = {o_backplane_bit_clock_oe, o_backplane_frame_pulse_oe, 4'h0, meas};
            default: act = {o_tdm_bit_clock, o_tdm_frame_pulse, 14'h0000};
        endcase
        n_tests++;
        if (act !== n.val)
        begin
            n_fail++;
            $display("BAD %0t kind %0d got %h want %h", $time, n.kind, act, n.val);
        end
    endtask

    // Watcher: a request taken at one edge is judged after the next edge
    always @(posedge i_clk)
    begin
        req_q <= req;
        req_q2 <= req_q;
    end
    always @(negedge i_clk)
        if (req_q2)
            judge(notes.pop_front());

    task automatic note(input logic [2:0] kind, input logic [15:0] val);
        notes.push_back({kind, val});
        req = 1'h1;
        @(negedge i_clk);
        req = 1'h0;
        i_cpu_read = 1'h0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic rd(input logic [15:0] addr, input logic [15:0] val);
        i_cpu_addr = addr;
        i_cpu_read = 1'h1;
        note(3'h0, val);
    endtask
    task automatic wr(input logic [15:0] addr, input logic [15:0] val);
        i_cpu_addr = addr;
        i_cpu_wdata = val;
        i_cpu_write = 1'h1;
        @(negedge i_clk);
        i_cpu_write = 1'h0;
        @(negedge i_clk);
    endtask
    function automatic logic [15:0] cfg(input int p);
        return tcsbt_pkg::CFG_BASE + tcsbt_pkg::CFG_STRIDE * 16'(p);
    endfunction
    task automatic wr_all(input logic [15:0] val);
        for (int p = 0; p < 8; p++)
            wr(cfg(p), val);
    endtask

    // Bit clock rises between active frame edges
    task automatic frame_len(input logic fmt);
        logic pb = o_tdm_bit_clock, pf = o_tdm_frame_pulse;
        int phase = 0, cnt = 0;
        for (int i = 0; i < 7000 && phase < 3; i++)
        begin
            @(negedge i_clk);
            if (o_tdm_bit_clock && !pb)
                cnt++;
            if (fmt ? (o_tdm_frame_pulse && !pf) : (!o_tdm_frame_pulse && pf))
            begin
                phase++;
                meas = 10'(cnt);
                cnt = 0;
            end
            pb = o_tdm_bit_clock;
            pf = o_tdm_frame_pulse;
        end
        if (phase < 3)
            meas = 10'h000;
    endtask

    // Hang guard well beyond the expected run length
    initial
    begin
        repeat (40000) @(posedge i_clk);
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end

    // Main sequence
    initial
    begin
        logic [7:0] iv, rv, lv;
        logic [3:0] sv, ss;
        logic [15:0] w, modes;
        logic ev, nv, pv, qv;
        void'($urandom(23015));
        repeat (5) @(negedge i_clk);
        i_reset_n = 1'h1;
        @(negedge i_clk);
        for (int p = 0; p < 8; p++)
            rd(cfg(p), tcsbt_pkg::CFG_RESET);
        note(3'h3, 16'h0000);
        // Random writes: only the low four bits stick
        for (int p = 0; p < 8; p++)
        begin
            w = 16'($urandom);
            modes[2*p +: 2] = w[3:2];
            wr(cfg(p), w);
            rd(cfg(p), w & tcsbt_pkg::CFG_WRITE_MASK);
        end
        note(3'h3, modes);
        wr(16'h5280, 16'h0001);
        rd(16'h5208, 16'h0000);
        rd(16'h5280, 16'h0000);
        // Static, distinct source levels expose each mux choice except the divided system clock
        iv = 8'($urandom);
        rv = ~iv;
        ev = 1'($urandom);
        i_port_input_clock = iv;
        i_port_recovered_clock = rv;
        ext_level = ev;
        i_common_external = 1'h1;
        wr_all(16'h0004);
        note(3'h1, {iv, 8'h00});
        wr_all(16'h0005);
        note(3'h1, {rv, 8'h00});
        wr_all(16'h0006);
        note(3'h1, {{8{ev}}, 8'h00});
        wr_all(16'h0000);
        lv = 8'($urandom) | 8'h01;
        i_signal_loss = lv;
        @(negedge i_clk);
        note(3'h1, {(iv & ~lv) | (rv & lv), lv});
        rd(cfg(0), 16'h0030);
        i_signal_loss = 8'h00;
        @(negedge i_clk);
        note(3'h1, {iv, 8'h00});
        note(3'h2, {iv, 3'h0, ev, iv[0], iv[0], 2'h0});
        // Every primary choice against a random secondary, under losses
        i_common_external = 1'h0;
        i_signal_loss = lv;
        wr_all(16'h0004);
        for (int k = 0; k < 16; k++)
        begin
            sv = 4'(k);
            ss = {~sv[3], 3'($urandom)};
            nv = 1'($urandom);
            i_primary_select = sv;
            i_secondary_select = ss;
            i_network_ref_8k = nv;
            pv = (lv[sv[2:0]] | sv[3]) ? rv[sv[2:0]] : iv[sv[2:0]];
            qv = ss[3] ? rv[ss[2:0]] : iv[ss[2:0]];
            @(negedge i_clk);
            note(3'h2, {{8{nv}}, 3'h0, pv, pv, qv, lv[sv[2:0]], lv[ss[2:0]]});
        end
        // Slave role: pin levels reach the TDM side unchanged
        i_backplane_mode = 1'h1;
        peer_drive = 1'h1;
        for (int v = 0; v < 4; v++)
        begin
            {peer_clock, peer_frame} = 2'(v);
            repeat (6) @(negedge i_clk);
            note(3'h5, {2'(v), 14'h0000});
        end
        note(3'h4, 16'h0000);
        // Master role at both rates, one frame shape each
        peer_drive = 1'h0;
        i_common_external = 1'h1;
        ext_run = 1'h1;
        for (int r = 0; r < 2; r++)
        begin
            i_backplane_master = 1'h1;
            i_backplane_double_rate = 1'(r);
            i_frame_format = 1'(r);
            frame_len(1'(r));
            note(3'h4, {2'h3, 4'h0, r ? 10'h200 : 10'h100});
            i_backplane_master = 1'h0;
            repeat (2) @(negedge i_clk);
        end
        wrap_up();
    end
endmodule
